/* File: verilog/parallel_port_mode_mux_regs.vh */
// Purpose: Register map and field layout of the parallel port mode mux
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes: Included by parallel_port_mode_mux.v
`ifndef PARALLEL_PORT_MODE_MUX_REGS_VH
`define PARALLEL_PORT_MODE_MUX_REGS_VH

// Byte offsets
`define OFS_BANK_SWITCH_CTRL 8'h00
`define OFS_GP_CTRL_A 8'h04
`define OFS_GP_CTRL_B 8'h08
`define OFS_PROC_MODE_STATUS 8'h0C
`define OFS_PORT_STATUS 8'h10

// Bank switch control fields
`define BSC_HOLDER_BIT 0
`define BSC_WAIT_LSB 4
`define BSC_WAIT_MSB 7
`define BSC_WAIT_W 4

// General-purpose pin three control fields
`define GPC_TIMER_SEL_BIT 0
`define GPC_DIR_OUT_BIT 1
`define GPC_OUT_VAL_BIT 2
`define GPC_PIN_IN_BIT 3

// Processor mode status fields
`define PMS_MP_BIT 0

// Port status fields
`define PST_EXT_MODE_BIT 0
`define PST_SUB_SEL_BIT 1
`define PST_ADDR_MUX_BIT 2
`define PST_BUSY_BIT 3

// Reset values and limits
`define RST_HOLDER_EN 1'b0
`define RST_WAIT_STATES 4'h0
`define RST_GP_CTRL 3'h0
`define READY_MIN_WAITS 4'h2

// Space codes of an access request
`define SPACE_PROGRAM 2'h0
`define SPACE_DATA 2'h1
`define SPACE_IO 2'h2

`endif

/* File: verilog/parallel_port_mode_mux.v */
// Purpose: Shared parallel port pin mux, external access sequencer and control regs
// Assumes: All inputs synchronous to clock_i; strobes and selects active low
// Notes: Notes on behaviour follow
// Notes on behaviour
// - Port mode select high gives external memory mode, low gives host port mode.
// - Data pins are a two-way external bus in memory mode and carry host data in host mode.
// - In memory mode with holders enabled, undriven data pins keep the last level the device drove.
// - Holders are off after reset and software switches them through the bank switch register.
// - Off pin low floats address, data, space selects and memory strobe.
// - Program select marks program accesses in memory mode and is host strobe one in host mode.
// - Data select marks data accesses in memory mode and is host strobe two in host mode.
// - I/O select marks I/O accesses in memory mode and is subsystem B pin three in host mode.
// - Memory strobe pulses for program and data accesses only in memory mode.
// - In host mode pin three of each subsystem is timer out when its select bit is 1, else GPIO.
// - At reset the microprocessor mode bit is loaded from mode select, mux mode and sub select.
// - In memory mode subsystem A owns the port when sub select is low, B when it is high.
// - With two or more wait states, ready low stretches the access by one cycle per sample.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "parallel_port_mode_mux_regs.vh"

module parallel_port_mode_mux #(
  parameter ADDR_W = 18,
  parameter DATA_W = 16,
  parameter [7:0] MP_INIT_TABLE = 8'h00
) (
  input wire clock_i,
  input wire sys_rst_i,
  // APB slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output reg pslverr_o,
  // Mode straps
  input wire port_mode_select_i,
  input wire host_addr_mux_mode_i,
  input wire subsystem_select_i,
  input wire emulation_or_off_pin_n_i,
  // Internal access request
  input wire ext_req_i,
  input wire ext_req_sub_b_i,
  input wire [1:0] ext_space_i,
  input wire ext_write_i,
  input wire [ADDR_W-1:0] ext_addr_i,
  input wire [DATA_W-1:0] ext_wdata_i,
  output wire ext_ack_o,
  output reg ext_done_o,
  output reg ext_refused_o,
  output reg [DATA_W-1:0] ext_rdata_o,
  input wire ready_i,
  // Host side towards internal memory
  input wire host_rd_drive_i,
  input wire [DATA_W-1:0] host_rd_data_i,
  output reg [ADDR_W-1:0] host_address_o,
  output reg [DATA_W-1:0] host_wdata_o,
  output reg host_data_strobe_first_o,
  output reg host_data_strobe_second_o,
  output reg microprocessor_mode_bit_o,
  // Timers
  input wire sub_a_timer_i,
  input wire sub_b_timer_i,
  // Address pins
  input wire [ADDR_W-1:0] port_address_pins_i,
  output reg [ADDR_W-1:0] port_address_pins_o,
  output wire port_address_pins_oe_o,
  // Data pins
  input wire [DATA_W-1:0] port_data_pins_i,
  output reg [DATA_W-1:0] port_data_pins_o,
  output wire port_data_pins_oe_o,
  // Space selects and strobe
  input wire program_space_select_n_i,
  output wire program_space_select_n_o,
  output wire program_space_select_n_oe_o,
  input wire data_space_select_n_i,
  output wire data_space_select_n_o,
  output wire data_space_select_n_oe_o,
  input wire io_space_select_n_i,
  output wire io_space_select_n_o,
  output wire io_space_select_n_oe_o,
  output wire memory_strobe_n_o,
  output wire memory_strobe_n_oe_o,
  output wire port_read_not_write_o,
  // Subsystem A pin three
  input wire sub_a_gp_pin_three_i,
  output wire sub_a_gp_pin_three_o,
  output wire sub_a_gp_pin_three_oe_o
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ACCESS = 1'b1;

  reg state;
  reg [`BSC_WAIT_W-1:0] wait_cnt;
  reg [1:0] acc_space;
  reg acc_write;
  reg bus_holder_enable;
  reg [`BSC_WAIT_W-1:0] wait_states;
  reg [2:0] gp_ctrl_a;
  reg [2:0] gp_ctrl_b;
  reg drove_data;

  wire ext_mode;
  wire host_mode;
  wire pins_on;
  wire apb_setup;
  wire apb_write;
  wire dev_drive;
  wire in_access;
  wire finish;

  assign ext_mode = port_mode_select_i;
  assign host_mode = ~port_mode_select_i;
  assign pins_on = emulation_or_off_pin_n_i;
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign in_access = (state == ST_ACCESS);
  assign finish = in_access & (wait_cnt == {`BSC_WAIT_W{1'b0}}) &
                  ((wait_states < `READY_MIN_WAITS) | ready_i);
  // Accept only from the owning subsystem while in memory mode
  assign ext_ack_o = (state == ST_IDLE) & ext_req_i & ext_mode &
                     (ext_req_sub_b_i == subsystem_select_i);

  // Pin three control word with the live pin level merged in
  function [31:0] gp_read;
    input [2:0] ctrl;
    input pin;
    begin
      gp_read = 32'h0000_0000;
      gp_read[`GPC_TIMER_SEL_BIT] = ctrl[`GPC_TIMER_SEL_BIT];
      gp_read[`GPC_DIR_OUT_BIT] = ctrl[`GPC_DIR_OUT_BIT];
      gp_read[`GPC_OUT_VAL_BIT] = ctrl[`GPC_OUT_VAL_BIT];
      gp_read[`GPC_PIN_IN_BIT] = pin;
    end
  endfunction

  // Pin three output value: timer or latched GPIO value
  function gp_out;
    input [2:0] ctrl;
    input timer;
    begin
      gp_out = ctrl[`GPC_TIMER_SEL_BIT] ? timer : ctrl[`GPC_OUT_VAL_BIT];
    end
  endfunction

  // Register writes and reset-time strap capture
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      bus_holder_enable <= `RST_HOLDER_EN;
      wait_states <= `RST_WAIT_STATES;
      gp_ctrl_a <= `RST_GP_CTRL;
      gp_ctrl_b <= `RST_GP_CTRL;
      microprocessor_mode_bit_o <= MP_INIT_TABLE[{port_mode_select_i,
        host_addr_mux_mode_i, subsystem_select_i}];
    end else if (apb_write) begin
      if (paddr_i == `OFS_BANK_SWITCH_CTRL) begin
        bus_holder_enable <= pwdata_i[`BSC_HOLDER_BIT];
        wait_states <= pwdata_i[`BSC_WAIT_MSB:`BSC_WAIT_LSB];
      end else if (paddr_i == `OFS_GP_CTRL_A) begin
        gp_ctrl_a <= pwdata_i[`GPC_OUT_VAL_BIT:`GPC_TIMER_SEL_BIT];
      end else if (paddr_i == `OFS_GP_CTRL_B) begin
        gp_ctrl_b <= pwdata_i[`GPC_OUT_VAL_BIT:`GPC_TIMER_SEL_BIT];
      end else if (paddr_i == `OFS_PROC_MODE_STATUS) begin
        microprocessor_mode_bit_o <= pwdata_i[`PMS_MP_BIT];
      end
    end
  end

  // Read data and error captured in the setup phase
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      if (paddr_i == `OFS_BANK_SWITCH_CTRL) begin
        prdata_o[`BSC_HOLDER_BIT] <= bus_holder_enable;
        prdata_o[`BSC_WAIT_MSB:`BSC_WAIT_LSB] <= wait_states;
      end else if (paddr_i == `OFS_GP_CTRL_A) begin
        prdata_o <= gp_read(gp_ctrl_a, sub_a_gp_pin_three_i);
      end else if (paddr_i == `OFS_GP_CTRL_B) begin
        prdata_o <= gp_read(gp_ctrl_b, io_space_select_n_i);
      end else if (paddr_i == `OFS_PROC_MODE_STATUS) begin
        prdata_o[`PMS_MP_BIT] <= microprocessor_mode_bit_o;
      end else if (paddr_i == `OFS_PORT_STATUS) begin
        prdata_o[`PST_EXT_MODE_BIT] <= ext_mode;
        prdata_o[`PST_SUB_SEL_BIT] <= subsystem_select_i;
        prdata_o[`PST_ADDR_MUX_BIT] <= host_addr_mux_mode_i;
        prdata_o[`PST_BUSY_BIT] <= in_access;
      end else begin
        pslverr_o <= 1'b1;
      end
    end
  end

  // External access sequencer
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      wait_cnt <= {`BSC_WAIT_W{1'b0}};
      acc_space <= `SPACE_PROGRAM;
      acc_write <= 1'b0;
      ext_done_o <= 1'b0;
      ext_refused_o <= 1'b0;
      ext_rdata_o <= {DATA_W{1'b0}};
      port_address_pins_o <= {ADDR_W{1'b0}};
    end else begin
      ext_done_o <= 1'b0;
      ext_refused_o <= (state == ST_IDLE) & ext_req_i & ~ext_ack_o;
      case (state)
        ST_IDLE: begin
          if (ext_ack_o) begin
            state <= ST_ACCESS;
            wait_cnt <= wait_states;
            acc_space <= ext_space_i;
            acc_write <= ext_write_i;
            port_address_pins_o <= ext_addr_i;
          end
        end
        ST_ACCESS: begin
          if (wait_cnt != {`BSC_WAIT_W{1'b0}}) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else if (finish) begin
            state <= ST_IDLE;
            ext_done_o <= 1'b1;
            ext_rdata_o <= port_data_pins_i;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Data pin value and holder memory of the last driven level
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      port_data_pins_o <= {DATA_W{1'b0}};
      drove_data <= 1'b0;
    end else if (ext_ack_o & ext_write_i) begin
      port_data_pins_o <= ext_wdata_i;
      drove_data <= 1'b1;
    end else if (host_mode & host_rd_drive_i) begin
      port_data_pins_o <= host_rd_data_i;
      drove_data <= 1'b1;
    end
  end

  // Host side capture of address, data and strobes
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      host_address_o <= {ADDR_W{1'b0}};
      host_wdata_o <= {DATA_W{1'b0}};
      host_data_strobe_first_o <= 1'b1;
      host_data_strobe_second_o <= 1'b1;
    end else if (host_mode) begin
      host_address_o <= port_address_pins_i;
      host_wdata_o <= port_data_pins_i;
      host_data_strobe_first_o <= program_space_select_n_i;
      host_data_strobe_second_o <= data_space_select_n_i;
    end else begin
      host_data_strobe_first_o <= 1'b1;
      host_data_strobe_second_o <= 1'b1;
    end
  end

  // Device drives data for its own writes or for host read returns
  assign dev_drive = (in_access & acc_write & ext_mode) | (host_mode & host_rd_drive_i);
  // Holder keeps the last driven level, yields to memory reads and the host
  assign port_data_pins_oe_o = pins_on & (dev_drive | (bus_holder_enable & drove_data &
    ext_mode & ~(in_access & ~acc_write)));
  assign port_address_pins_oe_o = pins_on & ext_mode;
  assign port_read_not_write_o = ~(in_access & acc_write);

  // Space selects, active low, only during an access of their space
  assign program_space_select_n_o = ~(in_access & (acc_space == `SPACE_PROGRAM));
  assign data_space_select_n_o = ~(in_access & (acc_space == `SPACE_DATA));
  assign program_space_select_n_oe_o = pins_on & ext_mode;
  assign data_space_select_n_oe_o = pins_on & ext_mode;
  assign memory_strobe_n_o = ~(in_access & (acc_space != `SPACE_IO));
  assign memory_strobe_n_oe_o = pins_on & ext_mode;

  // I/O select in memory mode, subsystem B pin three in host mode
  assign io_space_select_n_o = ext_mode ?
    ~(in_access & (acc_space == `SPACE_IO)) : gp_out(gp_ctrl_b, sub_b_timer_i);
  assign io_space_select_n_oe_o = pins_on & (ext_mode |
    gp_ctrl_b[`GPC_TIMER_SEL_BIT] | gp_ctrl_b[`GPC_DIR_OUT_BIT]);

  // Subsystem A pin three is only a GPIO or timer pin in host mode
  assign sub_a_gp_pin_three_o = gp_out(gp_ctrl_a, sub_a_timer_i);
  assign sub_a_gp_pin_three_oe_o = host_mode &
    (gp_ctrl_a[`GPC_TIMER_SEL_BIT] | gp_ctrl_a[`GPC_DIR_OUT_BIT]);

endmodule // parallel_port_mode_mux

/* File: testbench/parallel_port_mode_mux_asserts.sv */
// Purpose: Port checks for parallel_port_mode_mux
// Assumes: One clock, synchronous active-high reset
// Notes: Selects and strobe are active low
`timescale 1ns/1ps
module ppm_chk #(
  parameter [7:0] MP_INIT_TABLE = 8'h00
) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire port_mode_select_i,
  input wire host_addr_mux_mode_i,
  input wire subsystem_select_i,
  input wire emulation_or_off_pin_n_i,
  input wire ext_ack_o,
  input wire ext_req_sub_b_i,
  input wire [1:0] ext_space_i,
  input wire program_space_select_n_i,
  input wire data_space_select_n_i,
  input wire host_data_strobe_first_o,
  input wire host_data_strobe_second_o,
  input wire microprocessor_mode_bit_o,
  input wire port_address_pins_oe_o,
  input wire port_data_pins_oe_o,
  input wire program_space_select_n_o,
  input wire program_space_select_n_oe_o,
  input wire data_space_select_n_o,
  input wire io_space_select_n_o,
  input wire memory_strobe_n_o,
  input wire memory_strobe_n_oe_o,
  input wire host_rd_drive_i,
  input wire port_read_not_write_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  property p_off; !emulation_or_off_pin_n_i |-> !(port_address_pins_oe_o |
    port_data_pins_oe_o | program_space_select_n_oe_o | memory_strobe_n_oe_o); endproperty
  a_off: assert property (p_off) else $error("pins driven while off");
  property p_ext; port_mode_select_i && emulation_or_off_pin_n_i |->
    port_address_pins_oe_o && memory_strobe_n_oe_o; endproperty
  a_ext: assert property (p_ext) else $error("memory mode pins undriven");
  property p_host; !port_mode_select_i |-> !port_address_pins_oe_o && !memory_strobe_n_oe_o;
  endproperty
  a_host: assert property (p_host) else $error("host mode pins driven");
  property p_owner; ext_ack_o |-> port_mode_select_i && ext_req_sub_b_i == subsystem_select_i;
  endproperty
  a_owner: assert property (p_owner) else $error("access taken from non-owner");
  property p_prog; ext_ack_o && ext_space_i == 2'h0 |=> !program_space_select_n_o &&
    !memory_strobe_n_o && data_space_select_n_o; endproperty
  a_prog: assert property (p_prog) else $error("program access selects");
  property p_data; ext_ack_o && ext_space_i == 2'h1 |=> !data_space_select_n_o &&
    !memory_strobe_n_o && program_space_select_n_o; endproperty
  a_data: assert property (p_data) else $error("data access selects");
  property p_io; ext_ack_o && ext_space_i == 2'h2 |=> !io_space_select_n_o &&
    memory_strobe_n_o && program_space_select_n_o; endproperty
  a_io: assert property (p_io) else $error("io access selects");
  property p_hstrb; !port_mode_select_i |=> host_data_strobe_first_o ==
    $past(program_space_select_n_i) && host_data_strobe_second_o ==
    $past(data_space_select_n_i); endproperty
  a_hstrb: assert property (p_hstrb) else $error("host strobe copy");
  property p_hold; $fell(sys_rst_i) && port_mode_select_i |-> !port_data_pins_oe_o;
  endproperty
  a_hold: assert property (p_hold) else $error("holder on after reset");
  property p_mp; $fell(sys_rst_i) |-> microprocessor_mode_bit_o ==
    MP_INIT_TABLE[{port_mode_select_i, host_addr_mux_mode_i, subsystem_select_i}]; endproperty
  a_mp: assert property (p_mp) else $error("mode bit reset value");
  property p_rdfree; port_mode_select_i && port_read_not_write_o && !memory_strobe_n_o |->
    !port_data_pins_oe_o; endproperty
  a_rdfree: assert property (p_rdfree) else $error("data driven during read");
  property p_hdata; !port_mode_select_i && !host_rd_drive_i |-> !port_data_pins_oe_o;
  endproperty
  a_hdata: assert property (p_hdata) else $error("host data pins driven");
endmodule // ppm_chk
bind parallel_port_mode_mux ppm_chk #(.MP_INIT_TABLE(MP_INIT_TABLE)) ppm_chk_i (.*);

/* File: testbench/async_mem_model.sv */
// Purpose: Asynchronous memory on the far side of the port
// Assumes: Active-low selects, read while read_not_write is high
// Notes: Ready stays low for a set count of selected cycles
`timescale 1ns/1ps
module async_mem_model (
  input wire clock_i,
  input wire sel_n_i,
  input wire rnw_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire [3:0] stall_i,
  output wire drive_o,
  output wire [15:0] rdata_o,
  output wire ready_o
);
  reg [15:0] mem [0:15];
  reg [3:0] busy_cnt = 4'h0;
  assign drive_o = !sel_n_i && rnw_i;
  assign rdata_o = mem[addr_i];
  assign ready_o = busy_cnt >= stall_i;
  always @(posedge clock_i) begin
    busy_cnt <= sel_n_i ? 4'h0 : busy_cnt + 4'h1;
    if (!sel_n_i && !rnw_i) mem[addr_i] <= wdata_i;
  end
endmodule // async_mem_model

/* File: testbench/parallel_port_mode_mux_tb_top.sv */
// Purpose: Directed tests of parallel_port_mode_mux
// Assumes: Memory model on the port, host driven by the bench
// Notes: Mode bit table set to 8'hA5
`timescale 1ns/1ps
module parallel_port_mode_mux_tb_top;
  reg clock_i = 1'h0, sys_rst_i = 1'h1, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  reg port_mode_select_i = 1'h1, host_addr_mux_mode_i = 1'h0, subsystem_select_i = 1'h0;
  reg emulation_or_off_pin_n_i = 1'h1, ext_req_i = 1'h0, ext_req_sub_b_i = 1'h0;
  reg ext_write_i = 1'h0, host_rd_drive_i = 1'h0, sub_a_timer_i = 1'h1, sub_b_timer_i = 1'h1;
  reg hps = 1'h1, hds = 1'h1, his = 1'h1, hd_oe = 1'h0, er;
  reg [7:0] paddr_i = 8'h00;
  reg [31:0] pwdata_i = 32'h0, rd;
  reg [1:0] ext_space_i = 2'h0;
  reg [17:0] ext_addr_i = 18'h0, ha = 18'h0;
  reg [15:0] ext_wdata_i = 16'h0, host_rd_data_i = 16'h0, hd = 16'h0, last_d = 16'h0;
  reg [3:0] stall = 4'h0;
  integer errors = 0, samples_checked = 0, n, i;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, ext_ack_o, ext_done_o, ext_refused_o, host_data_strobe_first_o;
  wire host_data_strobe_second_o, microprocessor_mode_bit_o, port_address_pins_oe_o;
  wire port_data_pins_oe_o, program_space_select_n_o, program_space_select_n_oe_o;
  wire data_space_select_n_o, data_space_select_n_oe_o, io_space_select_n_o, mdrv, ready_i;
  wire io_space_select_n_oe_o, memory_strobe_n_o, memory_strobe_n_oe_o, port_read_not_write_o;
  wire sub_a_gp_pin_three_o, sub_a_gp_pin_three_oe_o, sub_a_gp_pin_three_i;
  wire program_space_select_n_i, data_space_select_n_i, io_space_select_n_i;
  wire [15:0] ext_rdata_o, host_wdata_o, port_data_pins_o, port_data_pins_i, mq;
  wire [17:0] host_address_o, port_address_pins_o, port_address_pins_i;
  assign port_address_pins_i = port_address_pins_oe_o ? port_address_pins_o : ha;
  assign port_data_pins_i = port_data_pins_oe_o ? port_data_pins_o : hd_oe ? hd :
    mdrv ? mq : ~last_d;
  assign program_space_select_n_i = program_space_select_n_oe_o ? program_space_select_n_o : hps;
  assign data_space_select_n_i = data_space_select_n_oe_o ? data_space_select_n_o : hds;
  assign io_space_select_n_i = io_space_select_n_oe_o ? io_space_select_n_o : his;
  assign sub_a_gp_pin_three_i = sub_a_gp_pin_three_oe_o ? sub_a_gp_pin_three_o : 1'h1;
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) last_d <= port_data_pins_i;
  parallel_port_mode_mux #(.MP_INIT_TABLE(8'hA5)) parallel_port_mode_mux_i (.*);
  async_mem_model async_mem_model_i (.clock_i(clock_i), .sel_n_i(program_space_select_n_i &
    data_space_select_n_i & io_space_select_n_i | !port_mode_select_i),
    .rnw_i(port_read_not_write_o), .addr_i(port_address_pins_i[3:0]),
    .wdata_i(port_data_pins_i), .stall_i(stall), .drive_o(mdrv), .rdata_o(mq),
    .ready_o(ready_i));
  task summarize;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'h1;
    @(posedge clock_i);
    while (pready_o !== 1'h1) @(posedge clock_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask
  task ext(input [1:0] s, input w, input [17:0] a, input [15:0] d);
    @(posedge clock_i);
    ext_req_i <= 1'h1;
    ext_space_i <= s;
    ext_write_i <= w;
    ext_addr_i <= a;
    ext_wdata_i <= d;
    ext_req_sub_b_i <= subsystem_select_i;
    @(negedge clock_i);
    chk(ext_ack_o, 32'h1);
    @(posedge clock_i);
    ext_req_i <= 1'h0;
    @(negedge clock_i);
    chk(port_address_pins_o, a);
    chk({program_space_select_n_o, data_space_select_n_o, io_space_select_n_o, memory_strobe_n_o,
      port_read_not_write_o}, {s != 2'h0, s != 2'h1, s != 2'h2, s == 2'h2, !w});
    n = 1;
    while (ext_done_o !== 1'h1 && n < 40) begin
      @(negedge clock_i);
      n = n + 1;
    end
  endtask
  initial begin
    #50000;
    errors = errors + 1;
    summarize;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    chk(microprocessor_mode_bit_o, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk(er, 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      ext(i[1:0], 1'h1, 18'h3 + i, 16'h5A00 + i);
      chk(n, 32'h2);
      @(negedge clock_i);
      chk(port_data_pins_oe_o, 32'h0);
      ext(i[1:0], 1'h0, 18'h3 + i, 16'h0);
      chk(ext_rdata_o, 16'h5A00 + i);
    end
    stall = 4'h4;
    apb(1'h1, 8'h00, 32'h21);
    ext(2'h0, 1'h0, 18'h3, 16'h0);
    chk(n, 32'h6);
    chk(ext_rdata_o, 32'h5A00);
    apb(1'h1, 8'h00, 32'h11);
    ext(2'h1, 1'h1, 18'h7, 16'hBEEF);
    chk(n, 32'h3);
    @(negedge clock_i);
    chk({port_data_pins_oe_o, port_data_pins_o}, 32'h1BEEF);
    stall = 4'h0;
    apb(1'h1, 8'h00, 32'h1);
    @(posedge clock_i);
    ext_req_i <= 1'h1;
    ext_req_sub_b_i <= 1'h1;
    @(negedge clock_i);
    chk(ext_ack_o, 32'h0);
    @(negedge clock_i);
    chk(ext_refused_o, 32'h1);
    @(posedge clock_i);
    ext_req_i <= 1'h0;
    subsystem_select_i <= 1'h1;
    ext(2'h0, 1'h1, 18'h9, 16'h1234);
    chk(n, 32'h2);
    @(posedge clock_i);
    emulation_or_off_pin_n_i <= 1'h0;
    subsystem_select_i <= 1'h0;
    @(negedge clock_i);
    chk({port_address_pins_oe_o, port_data_pins_oe_o, program_space_select_n_oe_o,
      data_space_select_n_oe_o, io_space_select_n_oe_o, memory_strobe_n_oe_o}, 32'h0);
    @(posedge clock_i);
    emulation_or_off_pin_n_i <= 1'h1;
    port_mode_select_i <= 1'h0;
    ha <= 18'h2A5C3;
    hd <= 16'h9C31;
    hd_oe <= 1'h1;
    hps <= 1'h0;
    repeat (2) @(negedge clock_i);
    chk(port_address_pins_oe_o, 32'h0);
    chk(host_address_o, 32'h2A5C3);
    chk(host_wdata_o, 32'h9C31);
    chk({host_data_strobe_first_o, host_data_strobe_second_o}, 32'h1);
    @(posedge clock_i);
    hd_oe <= 1'h0;
    host_rd_drive_i <= 1'h1;
    host_rd_data_i <= 16'h4D2E;
    repeat (2) @(negedge clock_i);
    chk({port_data_pins_oe_o, port_data_pins_o}, 32'h14D2E);
    @(posedge clock_i);
    host_rd_drive_i <= 1'h0;
    apb(1'h0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'h1, 8'h04, i == 0 ? 32'h1 : i == 1 ? 32'h6 : 32'h0);
      apb(1'h1, 8'h08, i == 0 ? 32'h1 : i == 1 ? 32'h6 : 32'h0);
      @(negedge clock_i);
      chk({sub_a_gp_pin_three_oe_o, sub_a_gp_pin_three_oe_o & sub_a_gp_pin_three_o},
        i == 2 ? 32'h0 : 32'h3);
      chk({io_space_select_n_oe_o, io_space_select_n_oe_o & io_space_select_n_o},
        i == 2 ? 32'h0 : 32'h3);
    end
    apb(1'h1, 8'h0C, 32'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h1);
    sys_rst_i <= 1'h1;
    subsystem_select_i <= 1'h1;
    port_mode_select_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    @(negedge clock_i);
    chk(microprocessor_mode_bit_o, 32'h1);
    summarize;
  end
endmodule // parallel_port_mode_mux_tb_top
